/* logic/pcdmux_pkg.sv */
// package of constants for the port c/d alternate function mux
`default_nettype none
package pcdmux_pkg;
    // ****************************************
    // pin positions
    // ****************************************
    localparam int unsigned PC_CAPTURE_BIT = 7;
    localparam int unsigned PD_COUNT0_BIT = 7;
    localparam int unsigned PD_COUNT1_BIT = 6;
    localparam int unsigned PD_SYNC_CLK_BIT = 5;
    localparam int unsigned PD_CAPTURE1_BIT = 4;
    localparam int unsigned PD_TXD_BIT = 3;
    localparam int unsigned PD_RXD_BIT = 2;
    localparam int unsigned PD_SDA_BIT = 1;
    localparam int unsigned PD_SCL_BIT = 0;
    localparam int unsigned PORT_WIDTH = 8;
    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned SPIKE_NS = 50;
    localparam int unsigned SPIKE_CYCLES = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [2:0] {
        PCD_FLT_STABLE = 3'b001,
        PCD_FLT_CHANGE = 3'b010,
        PCD_FLT_COMMIT = 3'b100
    } pcdmux_flt_state_t;
endpackage
`default_nettype wire

/* logic/pcdmux_spike_filter.sv */
// spike filter for one two-wire line
`timescale 1ns/1ps
`default_nettype none
module pcdmux_spike_filter
    import pcdmux_pkg::*;
#(
    parameter int unsigned CYCLES = pcdmux_pkg::SPIKE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic filtered
);
    import pcdmux_pkg::*;
    pcdmux_flt_state_t state;
    logic [7:0] count;
    // ****************************************
    // change must persist for CYCLES + 1 clocks
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PCD_FLT_STABLE;
            count <= 8'h00;
        end else begin
            case (state)
                PCD_FLT_STABLE: begin
                    count <= 8'h00;
                    if (raw != filtered) begin
                        state <= PCD_FLT_CHANGE;
                    end
                end
                PCD_FLT_CHANGE: begin
                    if (raw == filtered) begin
                        state <= PCD_FLT_STABLE;
                    end else if (count >= 8'(CYCLES - 1)) begin
                        state <= PCD_FLT_COMMIT;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                PCD_FLT_COMMIT: begin
                    state <= PCD_FLT_STABLE;
                end
                default: begin
                    state <= PCD_FLT_STABLE;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filtered <= 1'b1;
        end else if (state == PCD_FLT_COMMIT) begin
            filtered <= ~filtered;
        end
    end
endmodule
`default_nettype wire

/* logic/pcdmux_top.sv */
// alternate function mux for the upper port c pins and port d pins
// Summary of operation
// - pc7 input feeds timer3 capture
// - fuse puts prescaled clock on pc7
// - pc7 carries fast pwm a when output and the fuse is clear
// - pc6 carries inverted fast pwm a
// - pc6 can carry timer3 compare a
// - pc3 and pc2 get no function
// - pd7 input feeds timer0 count clock
// - pd7 carries fast pwm d when output
// - pd6 input feeds timer1 count clock
// - pd6 carries inverted fast pwm d
// - pd5 direction picks usart clock direction
// - usart clock only in synchronous mode
// - pd5 input is uart clear to send
// - pd4 input feeds timer1 capture
// - pd3..pd0 interrupts, usart, two-wire, compare b
// - two-wire takes pd1/pd0 open drain, filtered
`timescale 1ns/1ps
`default_nettype none
module pcdmux_top
    import pcdmux_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [pcdmux_pkg::PORT_WIDTH-1:0] portc_pin_in,
    input wire logic [pcdmux_pkg::PORT_WIDTH-1:0] portc_data,
    input wire logic [pcdmux_pkg::PORT_WIDTH-1:0] portc_direction,
    output logic [pcdmux_pkg::PORT_WIDTH-1:0] portc_pin_out,
    output logic [pcdmux_pkg::PORT_WIDTH-1:0] portc_pin_oe,
    input wire logic [pcdmux_pkg::PORT_WIDTH-1:0] portd_pin_in,
    input wire logic [pcdmux_pkg::PORT_WIDTH-1:0] portd_data,
    input wire logic [pcdmux_pkg::PORT_WIDTH-1:0] portd_direction,
    output logic [pcdmux_pkg::PORT_WIDTH-1:0] portd_pin_out,
    output logic [pcdmux_pkg::PORT_WIDTH-1:0] portd_pin_oe,
    output logic [pcdmux_pkg::PORT_WIDTH-1:0] portc_pin_value,
    output logic [pcdmux_pkg::PORT_WIDTH-1:0] portd_pin_value,
    input wire logic clock_out_fuse,
    input wire logic system_clock_prescaled,
    input wire logic fast_pwm_a_enable,
    input wire logic fast_pwm_a_out,
    input wire logic timer3_compare_a_enable,
    input wire logic timer3_compare_a_out,
    input wire logic fast_pwm_d_enable,
    input wire logic fast_pwm_d_out,
    input wire logic usart_sync_mode,
    input wire logic usart_sync_clock_out,
    input wire logic usart_transmit_enable,
    input wire logic usart_transmit_line,
    input wire logic usart_receive_enable,
    input wire logic two_wire_enable,
    input wire logic two_wire_data_out,
    input wire logic two_wire_clock_out,
    input wire logic timer0_compare_b_enable,
    input wire logic timer0_compare_b_out,
    output logic timer3_capture_input,
    output logic timer0_count_input,
    output logic timer1_count_input,
    output logic timer1_capture_input,
    output logic usart_sync_clock,
    output logic uart_clear_to_send,
    output logic usart_receive_line,
    output logic [3:0] external_interrupt_input,
    output logic two_wire_data_in,
    output logic two_wire_clock_in
);
    import pcdmux_pkg::*;
    logic [7:0] portc_meta;
    logic [7:0] portc_sync;
    logic [7:0] portd_meta;
    logic [7:0] portd_sync;
    logic [1:0] sync_fill;
    logic sda_filtered;
    logic scl_filtered;
    logic usart_clock_drive;
    logic [7:0] next_portc_out;
    logic [7:0] next_portc_oe;
    logic [7:0] next_portd_out;
    logic [7:0] next_portd_oe;
    // ****************************************
    // pin input synchronisers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portc_meta <= PORT_RESET;
            portc_sync <= PORT_RESET;
            portd_meta <= PORT_RESET;
            portd_sync <= PORT_RESET;
        end else begin
            portc_meta <= portc_pin_in;
            portc_sync <= portc_meta;
            portd_meta <= portd_pin_in;
            portd_sync <= portd_meta;
        end
    end
    // ****************************************
    // synchroniser fill tracking
    // ****************************************
    // alternate inputs wait for real pin levels, so no false low on idle-high lines
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_fill <= 2'h0;
        end else begin
            sync_fill <= {sync_fill[0], 1'h1};
        end
    end
    // ****************************************
    // two-wire spike filters
    // ****************************************
    pcdmux_spike_filter #(
        .CYCLES(SPIKE_CYCLES)
    ) u_sda_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw(portd_sync[PD_SDA_BIT]),
        .filtered(sda_filtered)
    );
    pcdmux_spike_filter #(
        .CYCLES(SPIKE_CYCLES)
    ) u_scl_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw(portd_sync[PD_SCL_BIT]),
        .filtered(scl_filtered)
    );
    // ****************************************
    // pin output selection
    // ****************************************
    assign usart_clock_drive = usart_sync_mode & portd_direction[PD_SYNC_CLK_BIT];
    always_comb begin
        // ordinary port control by default
        next_portc_out = portc_data;
        next_portc_oe = portc_direction;
        next_portd_out = portd_data;
        next_portd_oe = portd_direction;
        if (clock_out_fuse) begin
            next_portc_out[7] = system_clock_prescaled;
            next_portc_oe[7] = 1'b1;
        end else if (fast_pwm_a_enable && portc_direction[7]) begin
            next_portc_out[7] = fast_pwm_a_out;
        end
        if (fast_pwm_a_enable && portc_direction[6]) begin
            next_portc_out[6] = ~fast_pwm_a_out;
        end else if (timer3_compare_a_enable && portc_direction[6]) begin
            next_portc_out[6] = timer3_compare_a_out;
        end
        if (fast_pwm_d_enable && portd_direction[7]) begin
            next_portd_out[7] = fast_pwm_d_out;
        end
        if (fast_pwm_d_enable && portd_direction[6]) begin
            next_portd_out[6] = ~fast_pwm_d_out;
        end
        if (usart_clock_drive) begin
            next_portd_out[5] = usart_sync_clock_out;
        end
        if (usart_transmit_enable) begin
            next_portd_out[3] = usart_transmit_line;
            next_portd_oe[3] = 1'b1;
        end
        if (usart_receive_enable) begin
            next_portd_oe[2] = 1'b0;
        end
        if (two_wire_enable) begin
            next_portd_out[1] = 1'b0;
            next_portd_oe[1] = ~two_wire_data_out;
            next_portd_out[0] = 1'b0;
            next_portd_oe[0] = ~two_wire_clock_out;
        end else if (timer0_compare_b_enable) begin
            next_portd_out[0] = timer0_compare_b_out;
        end
        next_portc_out[3:2] = portc_data[3:2];
        next_portc_oe[3:2] = 2'b00;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portc_pin_out <= PORT_RESET;
            portc_pin_oe <= PORT_RESET;
            portd_pin_out <= PORT_RESET;
            portd_pin_oe <= PORT_RESET;
        end else begin
            portc_pin_out <= next_portc_out;
            portc_pin_oe <= next_portc_oe;
            portd_pin_out <= next_portd_out;
            portd_pin_oe <= next_portd_oe;
        end
    end
    // ****************************************
    // alternate inputs
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portc_pin_value <= PORT_RESET;
            portd_pin_value <= PORT_RESET;
            timer3_capture_input <= 1'b0;
            timer0_count_input <= 1'b0;
            timer1_count_input <= 1'b0;
            timer1_capture_input <= 1'b0;
            usart_sync_clock <= 1'b0;
            uart_clear_to_send <= 1'b0;
            usart_receive_line <= 1'b1;
            external_interrupt_input <= 4'h0;
            two_wire_data_in <= 1'b1;
            two_wire_clock_in <= 1'b1;
        end else if (sync_fill[1]) begin
            portc_pin_value <= {portc_sync[7:4], 2'b00, portc_sync[1:0]};
            portd_pin_value <= portd_sync;
            timer3_capture_input <= portc_sync[PC_CAPTURE_BIT];
            timer0_count_input <= portd_sync[PD_COUNT0_BIT];
            timer1_count_input <= portd_sync[PD_COUNT1_BIT];
            timer1_capture_input <= portd_sync[PD_CAPTURE1_BIT];
            if (usart_clock_drive) begin
                usart_sync_clock <= usart_sync_clock_out;
            end else if (usart_sync_mode) begin
                usart_sync_clock <= portd_sync[PD_SYNC_CLK_BIT];
            end else begin
                usart_sync_clock <= 1'b0;
            end
            uart_clear_to_send <= portd_sync[PD_SYNC_CLK_BIT];
            usart_receive_line <= portd_sync[PD_RXD_BIT];
            external_interrupt_input <= portd_sync[3:0];
            two_wire_data_in <= sda_filtered;
            two_wire_clock_in <= scl_filtered;
        end
    end
endmodule
`default_nettype wire

/* bench/pcdmux_chk.sv */
// assertion checker for the port c/d alternate function mux
`timescale 1ns/1ps
`default_nettype none
module pcdmux_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] portc_direction,
    input wire logic [7:0] portc_pin_out,
    input wire logic [7:0] portc_pin_oe,
    input wire logic [7:0] portc_pin_value,
    input wire logic [7:0] portd_pin_in,
    input wire logic [7:0] portd_direction,
    input wire logic [7:0] portd_pin_out,
    input wire logic [7:0] portd_pin_oe,
    input wire logic clock_out_fuse,
    input wire logic system_clock_prescaled,
    input wire logic fast_pwm_a_enable,
    input wire logic fast_pwm_a_out,
    input wire logic fast_pwm_d_enable,
    input wire logic fast_pwm_d_out,
    input wire logic usart_sync_mode,
    input wire logic usart_sync_clock_out,
    input wire logic usart_sync_clock,
    input wire logic timer1_capture_input
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    pc_unused_a: assert property (portc_pin_oe[3:2] == 2'h0 && portc_pin_value[3:2] == 2'h0)
        else $error("pc3 or pc2 active");
    clk_out_a: assert property ($past(rst_n) && $past(clock_out_fuse) |->
        portc_pin_oe[7] && portc_pin_out[7] == $past(system_clock_prescaled))
        else $error("pc7 clock wrong");
    pwm_a_true_a: assert property ($past(rst_n) &&
        $past(!clock_out_fuse && fast_pwm_a_enable && portc_direction[7]) |->
        portc_pin_oe[7] && portc_pin_out[7] == $past(fast_pwm_a_out))
        else $error("pc7 pwm wrong");
    pwm_a_inv_a: assert property ($past(rst_n) &&
        $past(fast_pwm_a_enable && portc_direction[6]) |->
        portc_pin_oe[6] && portc_pin_out[6] != $past(fast_pwm_a_out))
        else $error("pc6 wrong");
    pwm_d_pair_a: assert property ($past(rst_n) &&
        $past(fast_pwm_d_enable && portd_direction[7:6] == 2'h3) |->
        portd_pin_out[7:6] == {$past(fast_pwm_d_out), !$past(fast_pwm_d_out)})
        else $error("pd7/pd6 pwm wrong");
    sync_clk_a: assert property ($past(rst_n, 3) &&
        $past(usart_sync_mode && portd_direction[5]) |-> portd_pin_oe[5]
        && portd_pin_out[5] == $past(usart_sync_clock_out)
        && usart_sync_clock == $past(usart_sync_clock_out))
        else $error("pd5 out");
    async_clk_a: assert property ($past(!usart_sync_mode) |-> !usart_sync_clock)
        else $error("usart clock outside sync mode");
    capture_in_a: assert property ($past(rst_n, 3) |->
        timer1_capture_input == $past(portd_pin_in[4], 3)) else $error("pd4 capture late");
endmodule
bind pcdmux_top pcdmux_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .portc_direction(portc_direction), .portc_pin_out(portc_pin_out),
    .portc_pin_oe(portc_pin_oe), .portc_pin_value(portc_pin_value),
    .portd_pin_in(portd_pin_in), .portd_direction(portd_direction),
    .portd_pin_out(portd_pin_out), .portd_pin_oe(portd_pin_oe),
    .clock_out_fuse(clock_out_fuse), .system_clock_prescaled(system_clock_prescaled),
    .fast_pwm_a_enable(fast_pwm_a_enable), .fast_pwm_a_out(fast_pwm_a_out),
    .fast_pwm_d_enable(fast_pwm_d_enable), .fast_pwm_d_out(fast_pwm_d_out),
    .usart_sync_mode(usart_sync_mode), .usart_sync_clock_out(usart_sync_clock_out),
    .usart_sync_clock(usart_sync_clock), .timer1_capture_input(timer1_capture_input));
`default_nettype wire

/* bench/pcdmux_board.sv */
// board pads: the mux level while it drives, the board level otherwise
`timescale 1ns/1ps
`default_nettype none
module pcdmux_board (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext,
    output logic [7:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the port c/d alternate function mux
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pcdmux_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] portc_pin_in, portc_data, portc_direction, portc_pin_out, portc_pin_oe;
    logic [7:0] portd_pin_in, portd_data, portd_direction, portd_pin_out, portd_pin_oe;
    logic [7:0] portc_pin_value, portd_pin_value, ext_c, ext_d;
    logic clock_out_fuse, system_clock_prescaled, fast_pwm_a_enable, fast_pwm_a_out;
    logic timer3_compare_a_enable, timer3_compare_a_out, fast_pwm_d_enable, fast_pwm_d_out;
    logic usart_sync_mode, usart_sync_clock_out, usart_transmit_enable, usart_transmit_line;
    logic usart_receive_enable, two_wire_enable, two_wire_data_out, two_wire_clock_out;
    logic timer0_compare_b_enable, timer0_compare_b_out, timer3_capture_input;
    logic timer0_count_input, timer1_count_input, timer1_capture_input, usart_sync_clock;
    logic uart_clear_to_send, usart_receive_line, two_wire_data_in, two_wire_clock_in;
    logic [3:0] external_interrupt_input;
    int bad_count = 0;
    int n_tests = 0;
    // rows: {c dir 7:6, d dir 7:6, controls, expected c out/oe, d out/oe}
    localparam logic [19:0] ROWS [6] = '{20'h0_00_84, 20'hf_32_b7, 20'hf_23_7b, 20'h0_e0_a4,
        20'h6_0f_de, 20'h4_3f_94};
    pcdmux_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .portc_pin_in(portc_pin_in),
        .portc_data(portc_data), .portc_direction(portc_direction),
        .portc_pin_out(portc_pin_out), .portc_pin_oe(portc_pin_oe),
        .portd_pin_in(portd_pin_in), .portd_data(portd_data),
        .portd_direction(portd_direction), .portd_pin_out(portd_pin_out),
        .portd_pin_oe(portd_pin_oe), .portc_pin_value(portc_pin_value),
        .portd_pin_value(portd_pin_value), .clock_out_fuse(clock_out_fuse),
        .system_clock_prescaled(system_clock_prescaled),
        .fast_pwm_a_enable(fast_pwm_a_enable), .fast_pwm_a_out(fast_pwm_a_out),
        .timer3_compare_a_enable(timer3_compare_a_enable),
        .timer3_compare_a_out(timer3_compare_a_out),
        .fast_pwm_d_enable(fast_pwm_d_enable), .fast_pwm_d_out(fast_pwm_d_out),
        .usart_sync_mode(usart_sync_mode), .usart_sync_clock_out(usart_sync_clock_out),
        .usart_transmit_enable(usart_transmit_enable),
        .usart_transmit_line(usart_transmit_line),
        .usart_receive_enable(usart_receive_enable), .two_wire_enable(two_wire_enable),
        .two_wire_data_out(two_wire_data_out), .two_wire_clock_out(two_wire_clock_out),
        .timer0_compare_b_enable(timer0_compare_b_enable),
        .timer0_compare_b_out(timer0_compare_b_out),
        .timer3_capture_input(timer3_capture_input),
        .timer0_count_input(timer0_count_input), .timer1_count_input(timer1_count_input),
        .timer1_capture_input(timer1_capture_input), .usart_sync_clock(usart_sync_clock),
        .uart_clear_to_send(uart_clear_to_send), .usart_receive_line(usart_receive_line),
        .external_interrupt_input(external_interrupt_input),
        .two_wire_data_in(two_wire_data_in), .two_wire_clock_in(two_wire_clock_in));
    pcdmux_board pads_c (.pin_out(portc_pin_out), .pin_oe(portc_pin_oe), .ext(ext_c),
        .pin_in(portc_pin_in));
    pcdmux_board pads_d (.pin_out(portd_pin_out), .pin_oe(portd_pin_oe), .ext(ext_d),
        .pin_in(portd_pin_in));
    always #2.5 ref_clk = ~ref_clk;
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apply(input logic [19:0] r);
        portc_direction = {r[19:18], 6'h00};
        portd_direction = {r[17:16], 6'h00};
        {clock_out_fuse, system_clock_prescaled, fast_pwm_a_enable, fast_pwm_a_out,
            timer3_compare_a_enable, timer3_compare_a_out, fast_pwm_d_enable,
            fast_pwm_d_out} = r[15:8];
    endtask
    task automatic set_misc(input logic [9:0] v);
        {usart_sync_mode, usart_sync_clock_out, usart_transmit_enable, usart_transmit_line,
            usart_receive_enable, two_wire_enable, two_wire_data_out, two_wire_clock_out,
            timer0_compare_b_enable, timer0_compare_b_out} = v;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        {portc_data, portd_data, ext_c, ext_d} = 32'h8040_ffff;
        apply(ROWS[0]);
        set_misc(10'h000);
        tick(2);
        check(16'({portc_pin_oe | portd_pin_oe, two_wire_data_in, usart_receive_line}), 16'h3);
        tick(2);
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            apply(ROWS[i]);
            tick(2);
            check(16'({portc_pin_out[7:6], portc_pin_oe[7:6], portd_pin_out[7:6],
                portd_pin_oe[7:6]}), 16'(ROWS[i][7:0]));
        end
        set_misc(10'h020);
        for (int p = 0; p < 2; p++) begin
            ext_c = p ? 8'h5a : 8'ha5;
            ext_d = ext_c;
            tick(4);
            check(16'({timer3_capture_input, timer0_count_input, timer1_count_input,
                uart_clear_to_send, timer1_capture_input, external_interrupt_input}),
                16'({ext_c[7], ext_d}));
            check(16'(usart_receive_line), 16'(ext_d[2]));
            check(16'(portd_pin_value), 16'(ext_d));
        end
        {portc_data, portc_direction} = 16'hffff;
        tick(4);
        check(16'({portc_pin_oe, portc_pin_value}), 16'hf3b3);
        set_misc(10'h300);
        portd_direction = 8'h20;
        tick(2);
        check(16'({usart_sync_clock, portd_pin_oe[5], portd_pin_out[5]}), 16'h7);
        set_misc(10'h200);
        portd_direction = 8'h00;
        ext_d = 8'h23;
        tick(4);
        check(16'(usart_sync_clock), 16'h1);
        set_misc(10'h000);
        tick(2);
        check(16'({usart_sync_clock, portd_pin_oe[5]}), 16'h0);
        set_misc(10'h0c0);
        tick(2);
        check(16'({portd_pin_oe[3], portd_pin_out[3]}), 16'h3);
        set_misc(10'h013);
        portd_direction = 8'h01;
        tick(2);
        check(16'({portd_pin_oe[1:0], portd_pin_out[1:0]}), 16'hc);
        set_misc(10'h01f);
        tick(2);
        check(16'(portd_pin_oe[1:0]), 16'h0);
        ext_d[0] = 1'b0;
        tick(SPIKE_CYCLES / 2);
        ext_d[0] = 1'b1;
        tick(2 * SPIKE_CYCLES);
        check(16'({two_wire_data_in, two_wire_clock_in}), 16'h3);
        ext_d[0] = 1'b0;
        for (int i = 0; i < 4 * SPIKE_CYCLES && two_wire_clock_in !== 1'b0; i++) tick(1);
        check(16'(two_wire_clock_in), 16'h0);
        if (two_wire_clock_in !== 1'b0) print_verdict();
        set_misc(10'h003);
        tick(2);
        check(16'({portd_pin_oe[0], portd_pin_out[0]}), 16'h3);
        print_verdict();
    end
endmodule
`default_nettype wire
